// [design/flash_wr_defs.svh]
// timing, field and size constants for the flash page write controller
`ifndef FLASH_WR_DEFS_SVH
`define FLASH_WR_DEFS_SVH
`define KEY_FIRST 4'h5
`define KEY_SECOND 4'hA
`define FMOD_USER 2'h0
`define FMOD_USIG 2'h1
`define FMOD_FUSE 2'h2
`define FMOD_RSVD 2'h3
`define ERASED_BYTE 8'hFF
`define PAGE_BYTES 128
`define HALF_BYTES 64
`define CLK_MHZ 20
`define PROG_TIME_US 5
`define PROG_CYCLES (`PROG_TIME_US * `CLK_MHZ)
`endif

// [design/flash_wr_pkg.sv]
// types for the flash write controller; its cpu side does not use them
package flash_wr_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ERASE = 3'b010,
        ST_WRITE = 3'b100
    } seq_state_t;
    typedef logic [1:0] space_sel_t;
endpackage

// [design/flash_wr_if.sv]
// link between cpu core side and flash write controller
interface flash_wr_if;
    logic ctl_wr;
    logic [7:0] ctl_wdata;
    logic [7:0] ctl_rdata;
    logic ext_exec;
    logic auto_erase;
    logic buf_wr;
    logic [15:0] buf_addr;
    logic [7:0] buf_wdata;
    logic cpu_idle_req;
    logic irq_hold;
    logic flash_busy_flag;
    modport dev (input ctl_wr, input ctl_wdata, output ctl_rdata, input ext_exec,
        input auto_erase, input buf_wr, input buf_addr, input buf_wdata,
        output cpu_idle_req, output irq_hold, output flash_busy_flag);
    modport cpu (output ctl_wr, output ctl_wdata, input ctl_rdata, output ext_exec,
        output auto_erase, output buf_wr, output buf_addr, output buf_wdata,
        input cpu_idle_req, input irq_hold, input flash_busy_flag);
endinterface

// [design/flash_page_write_control.sv]
// device end: flash control register, page buffer and program/erase sequencer
// Contract
// - internal launch idles cpu during programming
// - cpu resumes at instruction after launch
// - peripherals run, interrupts held until done
// - external launch lets cpu keep executing
// - external software polls busy flag
// - external software keeps interrupts disabled
// - no internal branch until busy clears
// - boot routine callers disable interrupts
// - control maps spaces, launches, reports busy
// - write only clears ones to zeros
// - erase sets whole page to ff
// - rewrite allowed when only clearing bits
// - zero to one needs save erase rewrite
// - page request max 128 bytes aligned; one launch programs only the 64-byte half of the last load
// - busy set during programming, cleared after
// - launch needs key 5 then key a
`include "flash_wr_defs.svh"
module flash_page_write_control #(
    parameter int ADDR_W = 16,
    parameter int PROG_CYCLES = `PROG_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    flash_wr_if.dev link,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [7:0] rd_data
);
    localparam int CW = $clog2(PROG_CYCLES + 1);

    // refuse sizes the page index and counter cannot serve
    if (ADDR_W < 8 || ADDR_W > 16 || PROG_CYCLES < 1)
    begin
        $error("flash_page_write_control: unsupported parameters");
    end

    logic [7:0] array_r [0:(1 << ADDR_W)-1];
    logic [7:0] pbuf_r [0:`HALF_BYTES-1];
    logic [`HALF_BYTES-1:0] loaded_r;
    logic [ADDR_W-8:0] page_r;
    logic half_r;
    logic key_armed_r;
    logic [1:0] fmod_r;
    logic fps_r;
    logic busy_r;
    logic idle_r;
    logic [CW-1:0] cnt_r;
    flash_wr_pkg::seq_state_t state_r;
    logic launch;
    logic map_now;
    logic write_end;
    logic [5:0] load_idx;
    logic load_ok;

    // key decode for launch
    assign launch = link.ctl_wr && key_armed_r && link.ctl_wdata[7:4] == `KEY_SECOND
        && link.ctl_wdata[1:0] != `FMOD_RSVD && state_r == flash_wr_pkg::ST_IDLE;

    // map bit may arrive with the load itself, not only before it
    assign map_now = link.ctl_wr ? link.ctl_wdata[3] : fps_r;
    assign write_end = state_r == flash_wr_pkg::ST_WRITE && cnt_r == '0;
    assign load_idx = link.buf_addr[5:0];
    // a load on the clearing edge survives it, so no byte is lost
    assign load_ok = link.buf_wr && map_now && (!loaded_r[load_idx] || write_end);

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            key_armed_r <= 1'b0;
        else if (link.ctl_wr)
            key_armed_r <= link.ctl_wdata[7:4] == `KEY_FIRST;
        else
            key_armed_r <= 1'b0;
    end

    // space map and buffer map bits
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            fmod_r <= `FMOD_USER;
            fps_r <= 1'b0;
        end
        else if (link.ctl_wr)
        begin
            fmod_r <= link.ctl_wdata[1:0];
            fps_r <= link.ctl_wdata[3];
        end
    end

    // page buffer loads; a location takes one value only
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            loaded_r <= '0;
        else
        begin
            if (write_end)
                loaded_r <= '0;
            if (load_ok)
                loaded_r[load_idx] <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (load_ok)
            pbuf_r[load_idx] <= link.buf_wdata;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            page_r <= '0;
            half_r <= 1'b0;
        end
        else if (link.buf_wr && map_now)
        begin
            page_r <= link.buf_addr[ADDR_W-1:7];
            half_r <= link.buf_addr[6];
        end
    end

    // sequencer with program time counter
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_r <= flash_wr_pkg::ST_IDLE;
            cnt_r <= '0;
        end
        else
        begin
            unique case (state_r)
                flash_wr_pkg::ST_IDLE:
                    if (launch)
                    begin
                        state_r <= link.auto_erase ? flash_wr_pkg::ST_ERASE
                            : flash_wr_pkg::ST_WRITE;
                        cnt_r <= CW'(PROG_CYCLES - 1);
                    end
                flash_wr_pkg::ST_ERASE:
                    if (cnt_r == '0)
                    begin
                        state_r <= flash_wr_pkg::ST_WRITE;
                        cnt_r <= CW'(PROG_CYCLES - 1);
                    end
                    else
                        cnt_r <= cnt_r - 1'b1;
                flash_wr_pkg::ST_WRITE:
                    if (cnt_r == '0)
                        state_r <= flash_wr_pkg::ST_IDLE;
                    else
                        cnt_r <= cnt_r - 1'b1;
                default:
                    state_r <= flash_wr_pkg::ST_IDLE;
            endcase
        end
    end

    // array update at end of each phase, user space only modelled
    always_ff @(posedge ref_clk)
    begin
        if (cnt_r == '0 && fmod_r == `FMOD_USER)
        begin
            for (int i = 0; i < `PAGE_BYTES; i++)
            begin
                if (state_r == flash_wr_pkg::ST_ERASE)
                    array_r[{page_r, 7'(i)}] <= `ERASED_BYTE;
                else if (state_r == flash_wr_pkg::ST_WRITE && i[6] == half_r
                    && loaded_r[i[5:0]])
                    array_r[{page_r, 7'(i)}] <= array_r[{page_r, 7'(i)}] & pbuf_r[i[5:0]];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            busy_r <= 1'b0;
            idle_r <= 1'b0;
        end
        else if (launch)
        begin
            busy_r <= 1'b1;
            idle_r <= !link.ext_exec;
        end
        else if (state_r == flash_wr_pkg::ST_WRITE && cnt_r == '0)
        begin
            // release lets cpu take next instruction
            busy_r <= 1'b0;
            idle_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            rd_data <= '0;
        else
            rd_data <= array_r[rd_addr];
    end

    assign link.flash_busy_flag = busy_r;
    assign link.cpu_idle_req = idle_r;
    // interrupts held while internal write runs
    assign link.irq_hold = idle_r;
    assign link.ctl_rdata = {4'h0, fps_r, busy_r, fmod_r};
endmodule

// [design/flash_cpu_side.sv]
// cpu end: issues key sequence, loads buffer, waits on busy or idle
`include "flash_wr_defs.svh"
module flash_cpu_side (
    input wire logic ref_clk,
    input wire logic reset,
    flash_wr_if.cpu link,
    input wire logic req,
    input wire logic [1:0] space,
    input wire logic ext_mode,
    input wire logic erase_first,
    input wire logic ld_wr,
    input wire logic [15:0] ld_addr,
    input wire logic [7:0] ld_data,
    output logic done,
    output logic busy
);
    logic [1:0] step_r;
    logic was_busy_r;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            step_r <= 2'd0;
            link.ctl_wr <= 1'b0;
            link.ctl_wdata <= 8'h00;
            link.ext_exec <= 1'b0;
            link.auto_erase <= 1'b0;
            link.buf_wr <= 1'b0;
            link.buf_addr <= 16'h0000;
            link.buf_wdata <= 8'h00;
        end
        else
        begin
            link.ctl_wr <= 1'b0;
            link.buf_wr <= 1'b0;
            if (ld_wr && step_r == 2'd0)
            begin
                link.ctl_wr <= 1'b1;
                link.ctl_wdata <= {4'h0, 1'b1, 1'b0, space};
                link.buf_wr <= 1'b1;
                link.buf_addr <= ld_addr;
                link.buf_wdata <= ld_data;
            end
            else if (req && step_r == 2'd0 && !link.flash_busy_flag)
            begin
                link.ctl_wr <= 1'b1;
                link.ctl_wdata <= {`KEY_FIRST, 2'b00, space};
                link.ext_exec <= ext_mode;
                link.auto_erase <= erase_first;
                step_r <= 2'd1;
            end
            else if (step_r == 2'd1)
            begin
                link.ctl_wr <= 1'b1;
                link.ctl_wdata <= {`KEY_SECOND, 2'b00, space};
                step_r <= 2'd2;
            end
            else if (step_r == 2'd2)
                step_r <= 2'd0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            was_busy_r <= 1'b0;
            done <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            was_busy_r <= link.flash_busy_flag;
            done <= was_busy_r && !link.flash_busy_flag;
            busy <= link.flash_busy_flag || link.cpu_idle_req;
        end
    end
endmodule

// [verif/flash_wr_assertions.sv]
// concurrent checks on the link between the two flash write ends
module flash_wr_assertions #(
    parameter int PROG_CYCLES = 100
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ctl_wr,
    input wire logic [7:0] ctl_wdata,
    input wire logic [7:0] ctl_rdata,
    input wire logic ext_exec,
    input wire logic auto_erase,
    input wire logic cpu_idle_req,
    input wire logic irq_hold,
    input wire logic flash_busy_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [15:0] busy_cnt_r;
    logic erase_r;
    logic [3:0] key_nib;
    logic key_go;
    assign key_nib = ctl_wdata[7:4];
    assign key_go = ctl_wr && key_nib == 4'hA && ctl_wdata[1:0] != 2'h3 && !flash_busy_flag;
    // erase choice frozen at launch, since the level may move while busy
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            busy_cnt_r <= 16'h0000;
            erase_r <= 1'b0;
        end
        else
        begin
            busy_cnt_r <= flash_busy_flag ? busy_cnt_r + 16'h0001 : 16'h0000;
            erase_r <= flash_busy_flag ? erase_r : auto_erase;
        end
    end
    property p_int_idle; key_go && $past(ctl_wr) && $past(key_nib) == 4'h5 && !ext_exec
        |=> flash_busy_flag && cpu_idle_req; endproperty
    a_int_idle: assert property (p_int_idle) else $error("internal launch did not idle");
    property p_ext_run; key_go && $past(ctl_wr) && $past(key_nib) == 4'h5 && ext_exec
        |=> flash_busy_flag && !cpu_idle_req; endproperty
    a_ext_run: assert property (p_ext_run) else $error("external launch wrong");
    property p_irq; irq_hold == cpu_idle_req; endproperty
    a_irq: assert property (p_irq) else $error("irq hold differs from idle");
    property p_rise_key; $rose(flash_busy_flag) |-> $past(ctl_wr) && $past(key_nib) == 4'hA
        && $past(ctl_wr, 2) && $past(key_nib, 2) == 4'h5; endproperty
    a_rise_key: assert property (p_rise_key) else $error("busy without key pair");
    property p_idle_busy; cpu_idle_req |-> flash_busy_flag; endproperty
    a_idle_busy: assert property (p_idle_busy) else $error("idle without busy");
    property p_fall; $fell(flash_busy_flag) |-> !cpu_idle_req; endproperty
    a_fall: assert property (p_fall) else $error("idle outlived busy");
    property p_len; $fell(flash_busy_flag)
        |-> int'(busy_cnt_r) == (erase_r ? 2 * PROG_CYCLES : PROG_CYCLES); endproperty
    a_len: assert property (p_len) else $error("busy length wrong");
    property p_status; ctl_rdata[2] == flash_busy_flag; endproperty
    a_status: assert property (p_status) else $error("status bit not busy");
    property p_reserved; ctl_wr && key_nib == 4'hA && ctl_wdata[1:0] == 2'h3
        && !flash_busy_flag |=> !flash_busy_flag; endproperty
    a_reserved: assert property (p_reserved) else $error("reserved space launched");
endmodule

// [verif/test_flash_page_write_control.sv]
// self-checking bench for both ends of the flash write link
module test_flash_page_write_control;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PROG = 4;
    typedef struct packed {
        logic [1:0] space;
        logic ext;
        logic ers;
        logic [15:0] addr;
        logic [7:0] data;
        logic [15:0] addr2;
        logic [7:0] exp1;
        logic [7:0] exp2;
    } row_t;
    // array contents carry over from row to row
    // last row erases to restore ones
    row_t rows [6] = '{
        '{2'h0, 1'b0, 1'b1, 16'h0010, 8'hA5, 16'h0070, 8'hA5, 8'hFF},
        '{2'h0, 1'b1, 1'b0, 16'h0010, 8'h3C, 16'h0070, 8'h24, 8'hFF},
        '{2'h1, 1'b0, 1'b0, 16'h0010, 8'h00, 16'h0070, 8'h24, 8'hFF},
        '{2'h2, 1'b1, 1'b0, 16'h0010, 8'h00, 16'h0070, 8'h24, 8'hFF},
        '{2'h0, 1'b0, 1'b0, 16'h0050, 8'h0F, 16'h0010, 8'h0F, 8'h24},
        '{2'h0, 1'b1, 1'b1, 16'h0011, 8'h81, 16'h0050, 8'h81, 8'hFF}};
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic req = 1'b0;
    logic [1:0] space = 2'h0;
    logic ext_mode = 1'b0;
    logic erase_first = 1'b0;
    logic ld_wr = 1'b0;
    logic [15:0] ld_addr = 16'h0000;
    logic [7:0] ld_data = 8'h00;
    logic [15:0] rd_addr = 16'h0000;
    logic done;
    logic busy;
    logic [7:0] rd_data;
    logic idle_seen;
    logic busy_seen;
    logic [7:0] done_n;
    logic [7:0] busy_n;
    logic [7:0] d;
    int error_cnt = 0;
    int comparisons = 0;
    always #25 ref_clk = ~ref_clk;
    flash_wr_if link();
    flash_page_write_control #(.PROG_CYCLES(PROG)) u_flash_page_write_control (.ref_clk(ref_clk),
        .reset(reset), .link(link), .rd_addr(rd_addr), .rd_data(rd_data));
    flash_cpu_side u_flash_cpu_side (.ref_clk(ref_clk), .reset(reset), .link(link), .req(req),
        .space(space), .ext_mode(ext_mode), .erase_first(erase_first), .ld_wr(ld_wr),
        .ld_addr(ld_addr), .ld_data(ld_data), .done(done), .busy(busy));
    flash_wr_assertions #(.PROG_CYCLES(PROG)) u_flash_wr_assertions (.ref_clk(ref_clk),
        .reset(reset), .ctl_wr(link.ctl_wr), .ctl_wdata(link.ctl_wdata),
        .ctl_rdata(link.ctl_rdata), .ext_exec(link.ext_exec), .auto_erase(link.auto_erase),
        .cpu_idle_req(link.cpu_idle_req), .irq_hold(link.irq_hold),
        .flash_busy_flag(link.flash_busy_flag));
    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk1(input string name, input logic exp, input logic got);
        chk8(name, {7'h00, exp}, {7'h00, got});
    endtask
    // window outlasts an erase plus a write, so done must show inside it
    task automatic launch(input row_t r);
        idle_seen = 1'b0;
        busy_seen = 1'b0;
        done_n = 8'h00;
        busy_n = 8'h00;
        @(posedge ref_clk);
        {space, ext_mode, erase_first} <= {r.space, r.ext, r.ers};
        {ld_wr, ld_addr, ld_data} <= {1'b1, r.addr, r.data};
        @(posedge ref_clk);
        ld_wr <= 1'b0;
        req <= 1'b1;
        @(posedge ref_clk);
        req <= 1'b0;
        repeat (12 * PROG)
        begin
            @(negedge ref_clk);
            idle_seen |= link.cpu_idle_req;
            busy_seen |= link.flash_busy_flag;
            done_n += {7'h00, done};
            busy_n += {7'h00, busy};
        end
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge ref_clk);
        rd_addr <= a;
        @(posedge ref_clk);
        @(negedge ref_clk);
        d = rd_data;
    endtask
    task automatic stop_test;
        if (error_cnt == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #(50 * 4000);
        error_cnt++;
        stop_test();
    end
    initial
    begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        @(negedge ref_clk);
        chk1("busy_after_reset", 1'b0, link.flash_busy_flag);
        chk1("idle_after_reset", 1'b0, link.cpu_idle_req);
        foreach (rows[i])
        begin
            launch(rows[i]);
            chk1("idle_req", !rows[i].ext, idle_seen);
            chk8("busy_len", rows[i].ers ? 8'(2 * PROG) : 8'(PROG), busy_n);
            chk1("busy_seen", 1'b1, busy_seen);
            chk8("done_count", 8'h01, done_n);
            rd(rows[i].addr);
            chk8("byte_written", rows[i].exp1, d);
            rd(rows[i].addr2);
            chk8("byte_other", rows[i].exp2, d);
        end
        // reserved space must stay quiet
        launch('{2'h3, 1'b0, 1'b1, 16'h0010, 8'h00, 16'h0010, 8'h81, 8'h81});
        chk1("reserved_busy", 1'b0, busy_seen);
        chk8("reserved_done", 8'h00, done_n);
        chk8("reserved_len", 8'h00, busy_n);
        rd(16'h0010);
        chk8("reserved_byte", 8'hFF, d);
        stop_test();
    end
endmodule
